// ---- hdl/spl_cfg.svh ----
// Constants of the single-axis position servo: register offsets, reset values,
// scaling of the demand output and sample-period timing.
// Assumes a 10 MHz system clock and an 8-bit register address.
`ifndef SPL_CFG_SVH
`define SPL_CFG_SVH

// Clock rate and sample periods in their own unit
`define SPL_CLK_MHZ       10
`define SPL_T_2MS_US      2000
`define SPL_T_1MS_US      1000
`define SPL_T_500US_US    500
`define SPL_T_200US_US    200
`define SPL_T_100US_US    100
`define SPL_CYC_2MS       (`SPL_T_2MS_US * `SPL_CLK_MHZ)
`define SPL_CYC_1MS       (`SPL_T_1MS_US * `SPL_CLK_MHZ)
`define SPL_CYC_500US     (`SPL_T_500US_US * `SPL_CLK_MHZ)
`define SPL_CYC_200US     (`SPL_T_200US_US * `SPL_CLK_MHZ)
`define SPL_CYC_100US     (`SPL_T_100US_US * `SPL_CLK_MHZ)

// Demand scaling: full scale is 32000 counts, so one percent is 320 counts
`define SPL_FULL_SCALE    32000
`define SPL_PCT_SCALE     320
`define SPL_PCT_MAX       100
`define SPL_GAIN_FRAC     8

// Register offsets (byte addresses)
`define SPL_OFF_CTRL      8'h00
`define SPL_OFF_TORQUE    8'h04
`define SPL_OFF_DEM_POS   8'h08
`define SPL_OFF_DEM_SPD   8'h0C
`define SPL_OFF_DEM_ACC   8'h10
`define SPL_OFF_KP        8'h14
`define SPL_OFF_KV        8'h18
`define SPL_OFF_KD        8'h1C
`define SPL_OFF_KI        8'h20
`define SPL_OFF_KILIM     8'h24
`define SPL_OFF_KVFF      8'h28
`define SPL_OFF_KACC      8'h2C
`define SPL_OFF_MEAS_POS  8'h30
`define SPL_OFF_FERR      8'h34
`define SPL_OFF_DEMAND    8'h38
`define SPL_OFF_INTEG     8'h3C

// Reset values: servo mode, 1 ms period, integral on, limit 100 %
`define SPL_CTRL_RST      8'h90
`define SPL_KILIM_RST     8'h64

`endif

// ---- hdl/spl_pkg.sv ----
// Types shared by the position servo: modes, sample-period codes, control word
// and the quadrature pin pair. Constants live in spl_cfg.svh.
package spl_pkg;

    typedef enum logic [1:0] {
        SPL_MODE_SERVO  = 2'b00,
        SPL_MODE_TORQUE = 2'b01,
        SPL_MODE_STOP   = 2'b10,
        SPL_MODE_HOLD   = 2'b11
    } spl_mode_t;

    typedef enum logic [2:0] {
        SPL_SP_2MS   = 3'b000,
        SPL_SP_1MS   = 3'b001,
        SPL_SP_500US = 3'b010,
        SPL_SP_200US = 3'b011,
        SPL_SP_100US = 3'b100
    } spl_period_t;

    typedef struct packed {
        logic        integral_enable_mode;
        spl_period_t sample_period_sel;
        logic        quad_swap_cfg;
        logic        demand_invert_cfg;
        spl_mode_t   mode;
    } spl_ctrl_t;

    typedef struct packed {
        logic a;
        logic b;
    } spl_quad_t;

endpackage

// ---- hdl/spl_servo_loop.sv ----
// Single-axis closed-loop position servo with register port and 4x quadrature
// decoder. Drives a signed demand word toward an external drive amplifier.
// Assumes one 10 MHz clock, synchronous reset and encoder pins asynchronous.
//
// How it works
// - Torque command percent scales demand linearly
// - Stop mode forces demand to zero
// - Invert option negates demand output
// - Swap option exchanges quadrature channels
// - Each sample period recompute demand from error
// - Period selectable 2ms 1ms 500us 200us 100us
// - Following error is demanded minus measured
// - Proportional term is error times gain
// - Velocity feedback term subtracted from demand
// - Derivative term uses error change per sample
// - Integral term accumulates error times gain
// - Integral contribution clamped to percent limit
// - Integral mode off disables, default on
// - Speed feed-forward added outside feedback path
// - Acceleration feed-forward added to demand
// - Demand saturates at full scale both ways
// - All gains reset to zero
// - Limit of five gives five percent
`include "spl_cfg.svh"

module spl_servo_loop #(
    parameter int unsigned CYC_2MS   = `SPL_CYC_2MS,
    parameter int unsigned CYC_1MS   = `SPL_CYC_1MS,
    parameter int unsigned CYC_500US = `SPL_CYC_500US
) (
    input  wire logic               clk,
    input  wire logic               reset,
    input  wire logic [7:0]         reg_addr,
    input  wire logic [31:0]        reg_wdata,
    input  wire logic               reg_wr,
    input  wire logic               reg_rd,
    output logic [31:0]             reg_rdata,
    input  wire spl_pkg::spl_quad_t quad_input_ch0,
    output logic signed [15:0]      demand_out_ch0,
    output logic                    sample_tick
);

    // Saturate a wide signed value to +/- lim, returned as 16 bits
    function automatic logic signed [15:0] spl_clip(input logic signed [47:0] v,
                                                     input logic signed [47:0] lim);
        logic signed [47:0] r;
        r = v;
        if (v > lim) begin
            r = lim;
        end else if (v < -lim) begin
            r = -lim;
        end
        return r[15:0];
    endfunction

    localparam logic signed [47:0] FS48  = 48'(`SPL_FULL_SCALE);
    localparam logic signed [47:0] PCT48 = 48'(`SPL_PCT_SCALE);
    localparam logic signed [47:0] ERRLIM = 48'sh7F_FFFF;
    localparam logic signed [47:0] VELLIM = 48'sh7FFF;
    localparam logic signed [47:0] ACCLIM = 48'sh3FFF_FFFF;

    // Software-visible settings
    spl_pkg::spl_ctrl_t  ctrl_r,      ctrl_nxt;
    logic signed [7:0]   torque_r,    torque_nxt;
    logic signed [31:0]  dem_pos_r,   dem_pos_nxt;
    logic signed [15:0]  dem_spd_r,   dem_spd_nxt;
    logic signed [15:0]  dem_acc_r,   dem_acc_nxt;
    logic signed [15:0]  proportional_gain,      kp_nxt;
    logic signed [15:0]  velocity_feedback_gain, kv_nxt;
    logic signed [15:0]  derivative_gain,        kd_nxt;
    logic signed [15:0]  integral_gain,          ki_nxt;
    logic [7:0]          integral_clamp_pct,     kil_nxt;
    logic signed [15:0]  speed_feedforward_gain, kvff_nxt;
    logic signed [15:0]  accel_feedforward_gain, kacc_nxt;
    logic [31:0]         rdata_r,     rdata_nxt;

    // Encoder path
    spl_pkg::spl_quad_t  q_s1_r, q_s2_r, q_d_r, q_d_nxt;
    logic signed [31:0]  pos_r,  pos_nxt;

    // Sample timer
    logic [14:0]         tcnt_r, tcnt_nxt;
    logic [14:0]         tlast;
    logic                tick;
    logic                tick_r;

    // Loop state
    logic signed [23:0]  err_r,     err_nxt;
    logic signed [31:0]  pos_prv_r, pos_prv_nxt;
    logic signed [31:0]  acc_r,     acc_nxt;
    logic signed [15:0]  dem_r,     dem_nxt;

    // Loop arithmetic
    logic signed [47:0]  err_w, de_w, vel_w, sum_w, iprod_w, ilim_w, tq_w;
    logic signed [15:0]  err_c, vel_c, iterm_c, raw_c;

    // Register writes; gains reset to zero so the demand is zero after power-up
    always_comb begin
        ctrl_nxt    = ctrl_r;
        torque_nxt  = torque_r;
        dem_pos_nxt = dem_pos_r;
        dem_spd_nxt = dem_spd_r;
        dem_acc_nxt = dem_acc_r;
        kp_nxt      = proportional_gain;
        kv_nxt      = velocity_feedback_gain;
        kd_nxt      = derivative_gain;
        ki_nxt      = integral_gain;
        kil_nxt     = integral_clamp_pct;
        kvff_nxt    = speed_feedforward_gain;
        kacc_nxt    = accel_feedforward_gain;
        if (reg_wr) begin
            case (reg_addr)
                `SPL_OFF_CTRL:    ctrl_nxt    = spl_pkg::spl_ctrl_t'(reg_wdata[7:0]);
                `SPL_OFF_TORQUE:  torque_nxt  = reg_wdata[7:0];
                `SPL_OFF_DEM_POS: dem_pos_nxt = reg_wdata;
                `SPL_OFF_DEM_SPD: dem_spd_nxt = reg_wdata[15:0];
                `SPL_OFF_DEM_ACC: dem_acc_nxt = reg_wdata[15:0];
                `SPL_OFF_KP:      kp_nxt      = reg_wdata[15:0];
                `SPL_OFF_KV:      kv_nxt      = reg_wdata[15:0];
                `SPL_OFF_KD:      kd_nxt      = reg_wdata[15:0];
                `SPL_OFF_KI:      ki_nxt      = reg_wdata[15:0];
                `SPL_OFF_KILIM:   kil_nxt     = reg_wdata[7:0];
                `SPL_OFF_KVFF:    kvff_nxt    = reg_wdata[15:0];
                `SPL_OFF_KACC:    kacc_nxt    = reg_wdata[15:0];
                default:          ;
            endcase
        end
    end

    // Read mux; data stands only in the cycle after the strobe, else zero
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        if (reg_rd) begin
            case (reg_addr)
                `SPL_OFF_CTRL:     rdata_nxt = {24'h00_0000, ctrl_r};
                `SPL_OFF_TORQUE:   rdata_nxt = {{24{torque_r[7]}}, torque_r};
                `SPL_OFF_DEM_POS:  rdata_nxt = dem_pos_r;
                `SPL_OFF_DEM_SPD:  rdata_nxt = {{16{dem_spd_r[15]}}, dem_spd_r};
                `SPL_OFF_DEM_ACC:  rdata_nxt = {{16{dem_acc_r[15]}}, dem_acc_r};
                `SPL_OFF_KP:       rdata_nxt = {{16{proportional_gain[15]}}, proportional_gain};
                `SPL_OFF_KV:       rdata_nxt = {{16{velocity_feedback_gain[15]}},
                                                velocity_feedback_gain};
                `SPL_OFF_KD:       rdata_nxt = {{16{derivative_gain[15]}}, derivative_gain};
                `SPL_OFF_KI:       rdata_nxt = {{16{integral_gain[15]}}, integral_gain};
                `SPL_OFF_KILIM:    rdata_nxt = {24'h00_0000, integral_clamp_pct};
                `SPL_OFF_KVFF:     rdata_nxt = {{16{speed_feedforward_gain[15]}},
                                                speed_feedforward_gain};
                `SPL_OFF_KACC:     rdata_nxt = {{16{accel_feedforward_gain[15]}},
                                                accel_feedforward_gain};
                `SPL_OFF_MEAS_POS: rdata_nxt = pos_r;
                `SPL_OFF_FERR:     rdata_nxt = {{8{err_r[23]}}, err_r};
                `SPL_OFF_DEMAND:   rdata_nxt = {{16{demand_out_ch0[15]}}, demand_out_ch0};
                `SPL_OFF_INTEG:    rdata_nxt = acc_r;
                default:           rdata_nxt = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            ctrl_r                 <= spl_pkg::spl_ctrl_t'(`SPL_CTRL_RST);
            torque_r               <= 8'h00;
            dem_pos_r              <= 32'h0000_0000;
            dem_spd_r              <= 16'h0000;
            dem_acc_r              <= 16'h0000;
            proportional_gain      <= 16'h0000;
            velocity_feedback_gain <= 16'h0000;
            derivative_gain        <= 16'h0000;
            integral_gain          <= 16'h0000;
            integral_clamp_pct     <= `SPL_KILIM_RST;
            speed_feedforward_gain <= 16'h0000;
            accel_feedforward_gain <= 16'h0000;
            rdata_r                <= 32'h0000_0000;
        end else begin
            ctrl_r                 <= ctrl_nxt;
            torque_r               <= torque_nxt;
            dem_pos_r              <= dem_pos_nxt;
            dem_spd_r              <= dem_spd_nxt;
            dem_acc_r              <= dem_acc_nxt;
            proportional_gain      <= kp_nxt;
            velocity_feedback_gain <= kv_nxt;
            derivative_gain        <= kd_nxt;
            integral_gain          <= ki_nxt;
            integral_clamp_pct     <= kil_nxt;
            speed_feedforward_gain <= kvff_nxt;
            accel_feedforward_gain <= kacc_nxt;
            rdata_r                <= rdata_nxt;
        end
    end

    // 4x quadrature decode after a two-stage synchroniser. Channel swap is
    // applied behind the synchroniser so both channels keep equal latency.
    always_comb begin
        q_d_nxt = ctrl_r.quad_swap_cfg ? '{a: q_s2_r.b, b: q_s2_r.a} : q_s2_r;
        pos_nxt = pos_r;
        // A step where both channels change at once is an illegal jump; ignore it
        if ((q_d_nxt.a ^ q_d_r.a) != (q_d_nxt.b ^ q_d_r.b)) begin
            if (q_d_nxt.a ^ q_d_r.b) begin
                pos_nxt = pos_r + 32'sh1;
            end else begin
                pos_nxt = pos_r - 32'sh1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            q_s1_r <= '{a: 1'b0, b: 1'b0};
            q_s2_r <= '{a: 1'b0, b: 1'b0};
            q_d_r  <= '{a: 1'b0, b: 1'b0};
            pos_r  <= 32'h0000_0000;
        end else begin
            q_s1_r <= quad_input_ch0;
            q_s2_r <= q_s1_r;
            q_d_r  <= q_d_nxt;
            pos_r  <= pos_nxt;
        end
    end

    // Sample timer; unknown period codes fall back to the 1 ms default
    always_comb begin
        case (ctrl_r.sample_period_sel)
            spl_pkg::SPL_SP_2MS:   tlast = 15'(CYC_2MS - 1);
            spl_pkg::SPL_SP_1MS:   tlast = 15'(CYC_1MS - 1);
            spl_pkg::SPL_SP_500US: tlast = 15'(CYC_500US - 1);
            spl_pkg::SPL_SP_200US: tlast = 15'(`SPL_CYC_200US - 1);
            spl_pkg::SPL_SP_100US: tlast = 15'(`SPL_CYC_100US - 1);
            default:               tlast = 15'(CYC_1MS - 1);
        endcase
        // A shortened period that the count already passed restarts at once
        tick     = (tcnt_r >= tlast);
        tcnt_nxt = tick ? 15'h0000 : tcnt_r + 15'h0001;
    end

    // Control law. Gains carry 8 fractional bits; the sum is scaled once at
    // the end so small gains still contribute.
    always_comb begin
        err_w   = 48'(dem_pos_r) - 48'(pos_r);
        err_c   = 16'sh0;
        err_nxt = spl_clip(err_w, ERRLIM) == 16'sh0 && err_w == 48'sh0 ? 24'sh0 :
                  24'(err_w > ERRLIM ? ERRLIM : (err_w < -ERRLIM ? -ERRLIM : err_w));
        de_w    = 48'(err_nxt) - 48'(err_r);
        vel_w   = 48'(pos_r) - 48'(pos_prv_r);
        vel_c   = spl_clip(vel_w, VELLIM);
        // Integrator with its own saturation against wind-up
        acc_nxt = acc_r;
        if (!ctrl_r.integral_enable_mode) begin
            acc_nxt = 32'sh0;
        end else begin
            acc_nxt = 32'(spl_sat32(48'(acc_r) + 48'(err_nxt)));
        end
        iprod_w = (48'(integral_gain) * 48'(acc_nxt)) >>> `SPL_GAIN_FRAC;
        ilim_w  = 48'(integral_clamp_pct) * PCT48;
        iterm_c = spl_clip(iprod_w, ilim_w > FS48 ? FS48 : ilim_w);
        sum_w   = 48'(proportional_gain) * 48'(err_nxt)
                - 48'(velocity_feedback_gain) * 48'(vel_c)
                + 48'(derivative_gain) * de_w
                + 48'(speed_feedforward_gain) * 48'(dem_spd_r)
                + 48'(accel_feedforward_gain) * 48'(dem_acc_r);
        raw_c   = spl_clip((sum_w >>> `SPL_GAIN_FRAC) + 48'(iterm_c), FS48);
        tq_w    = 48'(torque_r) * PCT48;
        pos_prv_nxt = pos_r;
        dem_nxt = dem_r;
        case (ctrl_r.mode)
            spl_pkg::SPL_MODE_SERVO:  dem_nxt = raw_c;
            spl_pkg::SPL_MODE_TORQUE: dem_nxt = spl_clip(tq_w, FS48);
            default:                  dem_nxt = 16'sh0;
        endcase
        if (ctrl_r.mode != spl_pkg::SPL_MODE_SERVO) begin
            acc_nxt = 32'sh0;
        end
    end

    // Saturate to the integrator's range
    function automatic logic signed [47:0] spl_sat32(input logic signed [47:0] v);
        return v > ACCLIM ? ACCLIM : (v < -ACCLIM ? -ACCLIM : v);
    endfunction

    // Servo results land only on the sample tick; torque and stop act at once
    // so a stop never waits up to a full period
    always_ff @(posedge clk) begin
        if (reset) begin
            tcnt_r         <= 15'h0000;
            tick_r         <= 1'b0;
            err_r          <= 24'h00_0000;
            pos_prv_r      <= 32'h0000_0000;
            acc_r          <= 32'h0000_0000;
            dem_r          <= 16'h0000;
            demand_out_ch0 <= 16'h0000;
        end else begin
            tcnt_r <= tcnt_nxt;
            tick_r <= tick;
            if (tick || ctrl_r.mode != spl_pkg::SPL_MODE_SERVO) begin
                dem_r <= dem_nxt;
                acc_r <= acc_nxt;
            end
            if (tick) begin
                err_r     <= err_nxt;
                pos_prv_r <= pos_prv_nxt;
            end
            // Inversion is applied last so it also covers torque mode
            demand_out_ch0 <= ctrl_r.demand_invert_cfg ? -dem_r : dem_r;
        end
    end

    assign reg_rdata   = rdata_r;
    assign sample_tick = tick_r;

endmodule

// ---- verif/spl_loop_properties.sv ----
// Port-level checks of the servo loop, with a shadow of the mode and torque words.
// Assumes registers change only through reg_wr and one clock domain.
`include "spl_cfg.svh"

module spl_loop_chk #(
    parameter int unsigned CYC_2MS   = `SPL_CYC_2MS,
    parameter int unsigned CYC_1MS   = `SPL_CYC_1MS,
    parameter int unsigned CYC_500US = `SPL_CYC_500US
) (
    input wire logic               clk,
    input wire logic               reset,
    input wire logic [7:0]         reg_addr,
    input wire logic [31:0]        reg_wdata,
    input wire logic               reg_wr,
    input wire logic               reg_rd,
    input wire logic [31:0]        reg_rdata,
    input wire spl_pkg::spl_quad_t quad_input_ch0,
    input wire logic signed [15:0] demand_out_ch0,
    input wire logic               sample_tick
);
    logic [7:0]  ctrl_sh_r;
    logic [7:0]  ctrl_sh_nxt;
    logic [7:0]  tq_sh_r;
    logic [7:0]  tq_sh_nxt;
    logic [1:0]  age_r;
    logic [1:0]  age_nxt;
    logic [11:0] gap_r;
    logic [11:0] gap_nxt;
    int          tq_exp;

    // Age restarts on a write of the mode or torque word, so checks wait for it to settle
    always_comb begin
        ctrl_sh_nxt = ctrl_sh_r;
        tq_sh_nxt   = tq_sh_r;
        age_nxt     = (age_r == 2'h3) ? age_r : age_r + 2'h1;
        gap_nxt     = sample_tick ? 12'h000 : gap_r + 12'h001;
        if (reg_wr && reg_addr == `SPL_OFF_CTRL) begin
            ctrl_sh_nxt = reg_wdata[7:0];
            age_nxt     = 2'h0;
        end
        if (reg_wr && reg_addr == `SPL_OFF_TORQUE) begin
            tq_sh_nxt = reg_wdata[7:0];
            age_nxt   = 2'h0;
        end
        tq_exp = int'($signed(tq_sh_r)) * `SPL_PCT_SCALE;
        if (tq_exp > `SPL_FULL_SCALE)
            tq_exp = `SPL_FULL_SCALE;
        if (tq_exp < -`SPL_FULL_SCALE)
            tq_exp = -`SPL_FULL_SCALE;
        if (ctrl_sh_r[2])
            tq_exp = -tq_exp;
    end

    // Registers only
    always_ff @(posedge clk) begin
        if (reset) begin
            ctrl_sh_r <= `SPL_CTRL_RST;
            tq_sh_r   <= 8'h00;
            age_r     <= 2'h0;
            gap_r     <= 12'h000;
        end else begin
            ctrl_sh_r <= ctrl_sh_nxt;
            tq_sh_r   <= tq_sh_nxt;
            age_r     <= age_nxt;
            gap_r     <= gap_nxt;
        end
    end

    default clocking @(posedge clk);
    endclocking
    default disable iff (reset);

    AST_RESET_QUIET: assert property (disable iff (1'b0)
        reset |=> demand_out_ch0 == 16'h0000 && reg_rdata == 32'h0 && !sample_tick)
        else $error("outputs not quiet after reset");
    AST_RDATA_IDLE: assert property (!reg_rd |=> reg_rdata == 32'h0)
        else $error("read data present without a read");
    AST_CTRL_READBACK: assert property (reg_rd && reg_addr == `SPL_OFF_CTRL
        |=> reg_rdata == {24'h0, $past(ctrl_sh_r)})
        else $error("mode word read back wrong");
    AST_TICK_SPACING: assert property (sample_tick |=> !sample_tick [*8])
        else $error("sample ticks too close");
    AST_TICK_GAP: assert property (gap_r <= 12'h834)
        else $error("sample tick missing");
    AST_DEMAND_RANGE: assert property (demand_out_ch0 <= 16'sh7D00 &&
        demand_out_ch0 >= -16'sh7D00)
        else $error("demand beyond full scale");
    AST_SERVO_HOLD: assert property (age_r == 2'h3 && ctrl_sh_r[1:0] == 2'h0 &&
        $changed(demand_out_ch0) |-> $past(sample_tick))
        else $error("servo demand moved between samples");
    AST_STOP_ZERO: assert property (age_r == 2'h3 && ctrl_sh_r[1]
        |-> demand_out_ch0 == 16'h0000)
        else $error("stop mode demand not zero");
    AST_TORQUE_SCALE: assert property (age_r == 2'h3 && ctrl_sh_r[1:0] == 2'h1
        |-> demand_out_ch0 == 16'(tq_exp))
        else $error("torque demand wrong");
endmodule

bind spl_servo_loop spl_loop_chk #(
    .CYC_2MS(CYC_2MS), .CYC_1MS(CYC_1MS), .CYC_500US(CYC_500US)
) spl_loop_chk_i (
    .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .quad_input_ch0(quad_input_ch0), .demand_out_ch0(demand_out_ch0),
    .sample_tick(sample_tick)
);

// ---- verif/spl_quad_model.sv ----
// Motor encoder model: one quadrature step per fwd or rev pulse.
// Assumes the bench leaves at least four cycles between steps.
module spl_quad_model (
    input  wire logic          clk,
    input  wire logic          reset,
    input  wire logic          fwd,
    input  wire logic          rev,
    output spl_pkg::spl_quad_t quad
);
    logic [1:0] phase_r;

    // Gray order 00,10,11,01: one channel moves per step, as on a real disc
    always_ff @(posedge clk) begin
        if (reset) begin
            phase_r <= 2'h0;
        end else if (fwd) begin
            phase_r <= phase_r + 2'h1;
        end else if (rev) begin
            phase_r <= phase_r - 2'h1;
        end
    end
    assign quad.a = phase_r[1] ^ phase_r[0];
    assign quad.b = phase_r[1];
endmodule

// ---- verif/tb_top.sv ----
// Self-checking bench of the servo loop: registers, encoder, sample timing, demand.
// Assumes short period parameters 40/20/10 cycles for the three slow periods.
`include "spl_cfg.svh"

module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic               clk = 1'b0;
    logic               reset = 1'b1;
    logic [7:0]         reg_addr = 8'h00;
    logic [31:0]        reg_wdata = 32'h0;
    logic               reg_wr = 1'b0;
    logic               reg_rd = 1'b0;
    logic [31:0]        reg_rdata;
    spl_pkg::spl_quad_t quad;
    logic signed [15:0] demand_out_ch0;
    logic               sample_tick;
    logic               fwd = 1'b0;
    logic               rev = 1'b0;
    int                 n_fail = 0;
    int                 checks_done = 0;
    int                 cyc = 0;
    int                 per_tab [5] = '{40, 20, 10, 2000, 1000};
    logic [7:0]         gain_offs [6] = '{8'h14, 8'h18, 8'h1C, 8'h20, 8'h28, 8'h2C};

    always #50 clk = ~clk;

    spl_servo_loop #(.CYC_2MS(40), .CYC_1MS(20), .CYC_500US(10)) spl_servo_loop_i (
        .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .quad_input_ch0(quad),
        .demand_out_ch0(demand_out_ch0), .sample_tick(sample_tick));
    spl_quad_model spl_quad_model_i (.clk(clk), .reset(reset), .fwd(fwd), .rev(rev),
        .quad(quad));

    task automatic test_done();
        $display("checks=%0d mismatches=%0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Cuts a hang short; the whole run needs about 10000 cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            n_fail++;
            test_done();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Bus cycles start one edge in, so a strobe is never set and cleared in one step
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
        v = reg_rdata;
    endtask

    task automatic wait_tick(output int n);
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (sample_tick !== 1'b1 && n < 3000);
    endtask

    // Demand lands one edge after the tick is seen
    task automatic dem_at(input int skip, input logic [31:0] exp);
        int n;
        repeat (skip) wait_tick(n);
        @(posedge clk);
        chk(32'(demand_out_ch0), exp);
    endtask

    task automatic step(input logic dir, input int n);
        repeat (n) begin
            @(posedge clk);
            fwd <= dir;
            rev <= !dir;
            @(posedge clk);
            fwd <= 1'b0;
            rev <= 1'b0;
            repeat (4) @(posedge clk);
        end
    endtask

    task automatic t_reset();
        logic [31:0] v;
        rd(`SPL_OFF_CTRL, v);
        chk(v, 32'h90);
        rd(`SPL_OFF_KILIM, v);
        chk(v, 32'h64);
        foreach (gain_offs[i]) begin
            rd(gain_offs[i], v);
            chk(v, 32'h0);
        end
        rd(8'h40, v);
        chk(v, 32'h0);
        chk(32'(demand_out_ch0), 32'h0);
    endtask

    task automatic t_periods();
        int n;
        for (int i = 0; i < 5; i++) begin
            wr(`SPL_OFF_CTRL, 32'h80 | (i << 4));
            wait_tick(n);
            wait_tick(n);
            wait_tick(n);
            chk(n, per_tab[i]);
        end
        wr(`SPL_OFF_CTRL, 32'h90);
    endtask

    // Same pin sequence counted both ways; swap only changes at phase 00
    task automatic t_encoder();
        logic [31:0] p0;
        logic [31:0] v;
        step(1'b1, 4);
        rd(`SPL_OFF_MEAS_POS, p0);
        chk(p0[31] ? -p0 : p0, 32'h4);
        wr(`SPL_OFF_CTRL, 32'h98);
        step(1'b1, 4);
        rd(`SPL_OFF_MEAS_POS, v);
        chk(v, 32'h0);
        step(1'b0, 4);
        rd(`SPL_OFF_MEAS_POS, v);
        chk(v, p0);
        wr(`SPL_OFF_CTRL, 32'h90);
        step(1'b0, 4);
        rd(`SPL_OFF_MEAS_POS, v);
        chk(v, 32'h0);
    endtask

    task automatic t_servo();
        int n;
        wr(`SPL_OFF_KP, 32'h100);
        wr(`SPL_OFF_DEM_POS, 32'hA);
        dem_at(2, 32'hA);
        wait_tick(n);
        wr(`SPL_OFF_KD, 32'h200);
        wr(`SPL_OFF_DEM_POS, 32'h1E);
        dem_at(1, 32'h46);
        dem_at(1, 32'h1E);
        wr(`SPL_OFF_KP, 32'h0);
        wr(`SPL_OFF_KVFF, 32'h100);
        wr(`SPL_OFF_DEM_SPD, 32'h64);
        dem_at(2, 32'h64);
        wr(`SPL_OFF_KACC, 32'h100);
        wr(`SPL_OFF_DEM_ACC, 32'h7);
        dem_at(2, 32'h6B);
        wr(`SPL_OFF_DEM_SPD, 32'h0);
        wr(`SPL_OFF_DEM_ACC, 32'h0);
        wr(`SPL_OFF_KILIM, 32'h5);
        wr(`SPL_OFF_KI, 32'h100);
        wr(`SPL_OFF_DEM_POS, 32'h3E8);
        dem_at(5, 32'h640);
        wr(`SPL_OFF_CTRL, 32'h10);
        dem_at(2, 32'h0);
        wr(`SPL_OFF_KP, 32'h7FFF);
        dem_at(2, 32'h7D00);
        wr(`SPL_OFF_CTRL, 32'h14);
        dem_at(2, 32'hFFFF8300);
    endtask

    // Torque and stop act every edge; four edges cover the two-edge latency
    task automatic t_torque();
        wr(`SPL_OFF_TORQUE, 32'h5);
        wr(`SPL_OFF_CTRL, 32'h81);
        repeat (4) @(posedge clk);
        chk(32'(demand_out_ch0), 32'h640);
        wr(`SPL_OFF_TORQUE, 32'hFFFFFFFB);
        repeat (4) @(posedge clk);
        chk(32'(demand_out_ch0), 32'hFFFFF9C0);
        wr(`SPL_OFF_CTRL, 32'h85);
        repeat (4) @(posedge clk);
        chk(32'(demand_out_ch0), 32'h640);
        wr(`SPL_OFF_TORQUE, 32'h7F);
        repeat (4) @(posedge clk);
        chk(32'(demand_out_ch0), 32'hFFFF8300);
        for (int m = 2; m < 4; m++) begin
            wr(`SPL_OFF_CTRL, 32'h80 | m);
            repeat (4) @(posedge clk);
            chk(32'(demand_out_ch0), 32'h0);
        end
    endtask

    initial begin
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        t_reset();
        t_periods();
        t_encoder();
        t_servo();
        t_torque();
        test_done();
    end
endmodule
